// ===== nand_dev_model.sv
// nand_dev_model.sv: behavioural flash die for the host controller bench
// assumes strobes from nand_host_ctl; the bench merges the io bus
`timescale 1ns/1ns
module nand_dev_model (
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       read_strobe_n,
   input  wire logic [7:0] io_out,
   output logic      [7:0] dq,
   output logic            rb_n
);
   logic [7:0]  cmd, lcmd, fa, bs; // opcodes, feature address, data base
   logic [7:0]  ad [5];            // address bytes
   logic [31:0] fm [256];          // volatile feature store
   logic [15:0] col;               // read-out column
   logic [2:0]  ac, dc;            // address and parameter counts
   logic        pl;                // plane being read out
   initial begin
      rb_n = 1; dq = 8'h5A; cmd = 0; ac = 0; dc = 0; pl = 0; col = 0; bs = 0;
      foreach (fm[i]) fm[i] = 0;
   end
   task automatic go(input int t);
      rb_n = 0;
      fork #t rb_n = 1; join_none
   endtask : go
   // while busy only 70h and FFh are taken
   always @(posedge we_n) if (!ce_n && (rb_n || (cle && io_out inside {8'h70, 8'hFF}))) begin
      if (cle) begin
         lcmd = cmd; cmd = io_out; ac = 0; dc = 0;
         // confirm loads one page or a plane pair
         if (cmd == 8'h30) begin
            col = {ad[1], ad[0]}; pl = 0; bs = (lcmd == 8'hAF) ? ad[2] : 8'hA0; go(800);
         end
         // column move, 06h also picks the plane
         if (cmd == 8'hE0) begin
            col = {ad[1], ad[0]};
            if (lcmd == 8'h06) pl = ad[2][7];
         end
         if (cmd == 8'hFF) go(100);
      end else if (ale) begin
         ad[ac] = io_out; ac++; fa = io_out;
         if (cmd == 8'hEE) go(200);
      end else if (cmd == 8'hEF) begin
         fm[fa][8*dc+:8] = io_out; dc++;
         if (dc == 4) go(200);
      end
   end
   // bytes on strobe fall, status bits 6 and 5 follow busy
   always @(negedge read_strobe_n) if (!ce_n) begin
      if (cmd == 8'h70) dq = {1'b0, rb_n, rb_n, 5'h00};
      else if (cmd == 8'hEE) begin dq = fm[fa][8*dc+:8]; dc++; end
      else begin dq = bs + {3'b0, pl, 4'h0} + col[7:0]; col++; end
   end
   // released bus shows the inverse of its last value
   always @(posedge ce_n) dq = ~dq;
endmodule : nand_dev_model

// ===== nand_host_consts.svh
// nand_host_consts.svh: offsets, opcodes, field positions and timing counts
// assumes a 125 MHz pclk; included by the controller top module and the bench
//
// Overview of operation
// - one-time read: AFh, five address bytes, 30h
// - one-time read busy: only 70h, FFh allowed
// - further one-time pages need full sequence again
// - feature read EEh, write EFh, one address
// - feature read busy: only 70h, FFh allowed
// - host sends only 70h, FFh while busy
// - timing feature: reserved parameter bits written zero
// - plane pair: block lsb differs, msb, page match
// - two-plane read: 00h, addr, 00h, addr, 30h
// - plane 0 read first, then reselect plane
// - plane reselect: 06h, five address bytes, E0h
// - host never uses two-plane status read
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH

// ==========================================================
// register offsets on the apb side
`define REG_CTRL      12'h000
`define REG_COL       12'h004
`define REG_ROW0      12'h008
`define REG_ROW1      12'h00C
`define REG_FEAT      12'h010
`define REG_WDATA     12'h014
`define REG_RDATA     12'h018
`define REG_STAT      12'h01C

// ==========================================================
// control and status fields
`define CTRL_PLANE    4
`define STAT_BUSY     0
`define STAT_ERR      1
`define STAT_RB       2
`define ST_READY      6
`define ST_RB         5
`define ST_FAIL       0

// ==========================================================
// opcodes sent on the io bus
`define CMD_READ      8'h00
`define CMD_CONFIRM   8'h30
`define CMD_OTP_READ  8'hAF
`define CMD_GET_FEAT  8'hEE
`define CMD_SET_FEAT  8'hEF
`define CMD_PLANE_SEL 8'h06
`define CMD_COL_SEL   8'h05
`define CMD_COL_END   8'hE0
`define CMD_STATUS    8'h70
`define CMD_RESET     8'hFF

// ==========================================================
// feature map and address fields
`define FA_TIMING     8'h01
`define FA_CACHE      8'h02
`define FA_DRIVE      8'h80
`define FA_PULLDN     8'h81
`define TMODE_MASK    8'h07
`define OTP_PAGE_MIN  8'h02
`define OTP_PAGE_MAX  8'h0B
`define BA_LSB        7
`define BA_MSB        19
`define PA_MSB        6

// ==========================================================
// pin timing: times in ns, counts rounded up to whole cycles
`define CLK_NS        8
`define STROBE_NS     24
`define WB_NS         100
`define STROBE_CYC    ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_CYC        ((`WB_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== nand_host_ctl.sv
// nand_host_ctl.sv: apb-programmed controller driving nand flash pins
// assumes one die on ce_n, io and ready/busy asynchronous to pclk
`timescale 1ns/1ns
`include "nand_host_consts.svh"
module nand_host_ctl
   import nand_host_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             ce_n,
   output logic             cle,
   output logic             ale,
   output logic             we_n,
   output logic             read_strobe_n,
   output logic      [7:0]  io_out,
   output logic             io_oe,
   input  wire logic [7:0]  io_in,
   input  wire logic        rb_n
);

   // ==========================================================
   // state and synchronised pins
   ctl_state_t  st;        // registered state
   ctl_state_t  next_st;   // next state
   logic        rb_sync;   // ready/busy after two flops
   logic [7:0]  io_sync;   // data bus after two flops
   slot_t       cur;       // current sequence step
   logic        otp_ok;    // one-time page in range
   logic        pair_ok;   // plane pair legal
   logic        accept;    // order may start
   logic [31:0] rd_mux;    // apb read value
   logic        mapped;    // address hits a register
   order_t      new_order; // order in write data

   nand_host_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_rb_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (rb_n),
      .sync_out (rb_sync)
   );

   nand_host_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_io_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (io_in),
      .sync_out (io_sync)
   );

   // ==========================================================
   // address byte i of five: two column then three row
   function automatic logic [7:0] addr_byte(input logic [3:0] i, input logic [15:0] c,
                                            input logic [23:0] r);
      case (i)
         4'd0:    addr_byte = c[7:0];
         4'd1:    addr_byte = c[15:8];
         4'd2:    addr_byte = r[7:0];
         4'd3:    addr_byte = r[15:8];
         default: addr_byte = r[23:16];
      endcase
   endfunction : addr_byte

   // parameter byte i, reserved timing bits forced to zero
   function automatic logic [7:0] param_byte(input logic [3:0] i, input ctl_state_t s);
      logic [7:0] p;
      p = s.wdata[7:0];
      case (i)
         4'd1:    p = s.wdata[15:8];
         4'd2:    p = s.wdata[23:16];
         4'd3:    p = s.wdata[31:24];
         default: p = s.wdata[7:0];
      endcase
      if (s.feat == `FA_TIMING || s.feat == `FA_CACHE) begin
         p = (i == 4'd0) ? (p & `TMODE_MASK) : 8'h00;
      end
      param_byte = p;
   endfunction : param_byte

   // step k of the pin sequence for an order
   function automatic slot_t slot_of(input ctl_state_t s, input logic [3:0] k);
      slot_t       r;
      logic [23:0] row;
      r   = '{kind: K_END, data: 8'h00};
      row = s.plane ? s.row1 : s.row0;
      case (s.order)
         OP_OTP: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_OTP_READ};
            else if (k <= 4'd5) r = '{K_ADR, addr_byte(k - 4'd1, s.col, s.row0)};
            else if (k == 4'd6) r = '{K_CMD, `CMD_CONFIRM};
            else if (k == 4'd7) r = '{K_WAIT, 8'h00};
         end
         OP_TPREAD: begin
            if (k == 4'd0 || k == 4'd6) r = '{K_CMD, `CMD_READ};
            else if (k <= 4'd5) r = '{K_ADR, addr_byte(k - 4'd1, s.col, s.row0)};
            else if (k <= 4'd11) r = '{K_ADR, addr_byte(k - 4'd7, s.col, s.row1)};
            else if (k == 4'd12) r = '{K_CMD, `CMD_CONFIRM};
            else if (k == 4'd13) r = '{K_WAIT, 8'h00};
         end
         OP_RESEL: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_PLANE_SEL};
            else if (k <= 4'd5) r = '{K_ADR, addr_byte(k - 4'd1, s.col, row)};
            else if (k == 4'd6) r = '{K_CMD, `CMD_COL_END};
            else if (k == 4'd7) r = '{K_WAIT, 8'h00};
         end
         OP_RNDOUT: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_COL_SEL};
            else if (k <= 4'd2) r = '{K_ADR, addr_byte(k - 4'd1, s.col, row)};
            else if (k == 4'd3) r = '{K_CMD, `CMD_COL_END};
            else if (k == 4'd4) r = '{K_WAIT, 8'h00};
         end
         OP_GETF: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_GET_FEAT};
            else if (k == 4'd1) r = '{K_ADR, s.feat};
            else if (k == 4'd2) r = '{K_WAIT, 8'h00};
            else if (k <= 4'd6) r = '{K_DOUT, 8'h00};
         end
         OP_SETF: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_SET_FEAT};
            else if (k == 4'd1) r = '{K_ADR, s.feat};
            else if (k <= 4'd5) r = '{K_DIN, param_byte(k - 4'd2, s)};
            else if (k == 4'd6) r = '{K_WAIT, 8'h00};
         end
         OP_STATUS: begin // plain status read only
            if (k == 4'd0) r = '{K_CMD, `CMD_STATUS};
            else if (k == 4'd1) r = '{K_WAIT, 8'h00};
            else if (k == 4'd2) r = '{K_DOUT, 8'h00};
         end
         OP_RESET: begin
            if (k == 4'd0) r = '{K_CMD, `CMD_RESET};
            else if (k == 4'd1) r = '{K_WAIT, 8'h00};
         end
         OP_DATA: begin
            if (k <= 4'd3) r = '{K_DOUT, 8'h00};
         end
         default: r = '{K_END, 8'h00};
      endcase
      slot_of = r;
   endfunction : slot_of

   // ==========================================================
   // order checks and apb read mux
   always_comb begin
      cur       = slot_of(st, st.slot);
      new_order = order_t'(pwdata[3:0]);
      otp_ok    = (st.row0[23:8] == 16'h0000) && (st.row0[7:0] >= `OTP_PAGE_MIN)
                  && (st.row0[7:0] <= `OTP_PAGE_MAX);
      pair_ok   = !st.row0[`BA_LSB] && st.row1[`BA_LSB]
                  && (st.row0[`BA_MSB] == st.row1[`BA_MSB])
                  && (st.row0[`PA_MSB:0] == st.row1[`PA_MSB:0]);
      // busy device: only status or reset
      accept    = (st.phase == S_IDLE) && (new_order inside {OP_OTP, OP_GETF, OP_SETF,
                  OP_TPREAD, OP_RESEL, OP_RNDOUT, OP_STATUS, OP_RESET, OP_DATA})
                  && (rb_sync || new_order == OP_STATUS || new_order == OP_RESET)
                  && (new_order != OP_OTP || otp_ok) && (new_order != OP_TPREAD || pair_ok);
      mapped    = 1'b1;
      case (paddr)
         `REG_CTRL:  rd_mux = {27'h000_0000, st.plane, st.order};
         `REG_COL:   rd_mux = {16'h0000, st.col};
         `REG_ROW0:  rd_mux = {8'h00, st.row0};
         `REG_ROW1:  rd_mux = {8'h00, st.row1};
         `REG_FEAT:  rd_mux = {24'h00_0000, st.feat};
         `REG_WDATA: rd_mux = st.wdata;
         `REG_RDATA: rd_mux = st.rdata;
         `REG_STAT:  rd_mux = {16'h0000, st.status, 5'h00, rb_sync, st.err,
                               st.phase != S_IDLE};
         default: begin
            rd_mux = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // next state: apb slave and pin sequencer
   always_comb begin
      next_st = st;
      // setup cycle: answer in next cycle
      if (psel && !penable && !st.pready) begin
         next_st.pready  = 1'b1;
         next_st.prdata  = rd_mux;
         next_st.pslverr = !mapped || (pwrite && (paddr == `REG_RDATA));
      end
      // access edge: write takes effect
      if (psel && penable && st.pready) begin
         next_st.pready  = 1'b0;
         next_st.pslverr = 1'b0;
         if (pwrite && mapped) begin
            case (paddr)
               `REG_COL:   next_st.col   = pwdata[15:0];
               `REG_ROW0:  next_st.row0  = pwdata[23:0];
               `REG_ROW1:  next_st.row1  = pwdata[23:0];
               `REG_FEAT:  next_st.feat  = pwdata[7:0];
               `REG_WDATA: next_st.wdata = pwdata;
               // error flag is write one to clear
               `REG_STAT:  if (pwdata[`STAT_ERR]) next_st.err = 1'b0;
               `REG_CTRL: begin
                  if (accept) begin
                     next_st.order = new_order;
                     next_st.plane = pwdata[`CTRL_PLANE];
                     next_st.slot  = 4'd0;
                     next_st.ce_n  = 1'b0;
                     next_st.phase = S_FETCH;
                  end else begin
                     next_st.err   = 1'b1;
                  end
               end
               default: next_st.err = st.err;
            endcase
         end
      end
      case (st.phase)
         S_IDLE: next_st.io_oe = 1'b0;
         // start one step of the sequence
         S_FETCH: begin
            next_st.cle    = (cur.kind == K_CMD);
            next_st.ale    = (cur.kind == K_ADR);
            next_st.io_out = cur.data;
            case (cur.kind)
               K_CMD, K_ADR, K_DIN: begin
                  next_st.io_oe = 1'b1;
                  next_st.we_n  = 1'b0;
                  next_st.cnt   = 5'(`STROBE_CYC - 1);
                  next_st.phase = S_LOW;
               end
               // read strobe held longer to cover the input flops
               K_DOUT: begin
                  next_st.io_oe         = 1'b0;
                  next_st.read_strobe_n = 1'b0;
                  next_st.cnt           = 5'(`STROBE_CYC + 1);
                  next_st.phase         = S_LOW;
               end
               K_WAIT: begin
                  next_st.io_oe = 1'b0;
                  next_st.cnt   = 5'(`WB_CYC - 1);
                  next_st.phase = S_WB;
               end
               default: begin
                  next_st.io_oe = 1'b0;
                  next_st.ce_n  = 1'b1;
                  next_st.phase = S_IDLE;
               end
            endcase
         end
         S_LOW: begin
            if (st.cnt == 5'd0) begin
               if (!st.read_strobe_n) begin
                  if (st.order == OP_STATUS) next_st.status = io_sync;
                  else next_st.rdata = {io_sync, st.rdata[31:8]};
               end
               next_st.we_n          = 1'b1;
               next_st.read_strobe_n = 1'b1;
               next_st.cnt           = 5'(`STROBE_CYC - 1);
               next_st.phase         = S_HIGH;
            end else begin
               next_st.cnt = st.cnt - 5'd1;
            end
         end
         S_HIGH: begin
            if (st.cnt == 5'd0) begin
               next_st.cle   = 1'b0;
               next_st.ale   = 1'b0;
               next_st.slot  = st.slot + 4'd1;
               next_st.phase = S_FETCH;
            end else begin
               next_st.cnt = st.cnt - 5'd1;
            end
         end
         // settle before ready/busy is trusted
         S_WB: begin
            if (st.cnt == 5'd0) next_st.phase = S_RB;
            else next_st.cnt = st.cnt - 5'd1;
         end
         S_RB: begin
            if (rb_sync) begin
               next_st.slot  = st.slot + 4'd1;
               next_st.phase = S_FETCH;
            end
         end
         default: next_st.phase = S_IDLE;
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st               <= '0;
         st.phase         <= S_IDLE;
         st.order         <= OP_NONE;
         st.ce_n          <= 1'b1;
         st.we_n          <= 1'b1;
         st.read_strobe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata        = st.prdata;
   assign pready        = st.pready;
   assign pslverr       = st.pslverr;
   assign ce_n          = st.ce_n;
   assign cle           = st.cle;
   assign ale           = st.ale;
   assign we_n          = st.we_n;
   assign read_strobe_n = st.read_strobe_n;
   assign io_out        = st.io_out;
   assign io_oe         = st.io_oe;

   // ==========================================================
   // assertions
   sequence apb_setup_s;
      psel && !penable && !st.pready;
   endsequence
   sequence start_s;
      st.phase == S_IDLE ##1 st.phase == S_FETCH && st.slot == 4'd0;
   endsequence

   apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_setup_s |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");
   strobe_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(we_n) |-> (!we_n)[*3] ##1 we_n)
      else $error("write strobe low time wrong");
   otp_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_s ##0 st.order == OP_OTP |=> cle && !we_n && io_out == `CMD_OTP_READ)
      else $error("one-time read does not open with its opcode");
   otp_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_s ##0 st.order == OP_OTP |-> st.row0[7:0] >= `OTP_PAGE_MIN
                                       && st.row0[7:0] <= `OTP_PAGE_MAX)
      else $error("one-time page outside window");
   busy_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.phase == S_RB |-> we_n && read_strobe_n && !io_oe)
      else $error("strobe while device busy");
   plane_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_s ##0 st.order == OP_TPREAD |-> st.row0[`BA_LSB] != st.row1[`BA_LSB]
          && st.row0[`PA_MSB:0] == st.row1[`PA_MSB:0])
      else $error("illegal plane pair started");
   tp_cmds_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(we_n) && cle && st.order == OP_TPREAD |->
          io_out == `CMD_READ || io_out == `CMD_CONFIRM)
      else $error("wrong opcode in two-plane read");
   feat_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(we_n) && !cle && !ale && st.order == OP_SETF && st.feat == `FA_TIMING |->
          (st.slot == 4'd2 ? (io_out & ~`TMODE_MASK) == 8'h00 : io_out == 8'h00))
      else $error("reserved timing bits driven");
   busy_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && st.pready && pwrite && paddr == `REG_CTRL && !rb_sync
          && pwdata[3:0] == 4'b0011 |=> st.err && $stable(st.order))
      else $error("order taken while device busy");
   wait_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st.phase == S_WB) |-> (st.phase == S_WB)[*8] ##6 st.phase == S_RB)
      else $error("ready/busy sampled too early");

endmodule : nand_host_ctl

// ===== nand_host_ctl_test.sv
// nand_host_ctl_test.sv: self-checking bench for the nand host controller
// assumes nand_dev_model on the pins and apb driven from here
`timescale 1ns/1ns
`include "nand_host_consts.svh"
`define CHK(nm, e, v) begin n_tests++; if ((v) !== (e)) begin bad_count++; \
   $display("Error %s exp %h got %h", nm, e, v); end end
module nand_host_ctl_test import nand_host_pkg::*;;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, io_oe, rb_n, se;
   logic [7:0] io_out, dq, io_in;
   int bad_count = 0, n_tests = 0, cyc = 0;
   // feature rows: address, written word, word read back
   logic [7:0] fa [4] = '{8'h01, 8'h02, 8'h80, 8'h81};
   logic [31:0] wd [4] = '{32'hFFFF_FF05, 32'h0000_00FB, 32'h1234_5678, 32'hA5A5_0102};
   logic [31:0] ex [4] = '{32'h0000_0005, 32'h0000_0003, 32'h1234_5678, 32'hA5A5_0102};
   assign io_in = io_oe ? io_out : dq;
   nand_host_ctl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_out,
      .io_oe, .io_in, .rb_n);
   nand_dev_model dev_u (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_out, .dq, .rb_n);
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin bad_count++; final_report(); end
   end
   task automatic final_report;
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; se = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic run(input order_t o, input logic p);
      apb(1, `REG_CTRL, {27'h0, p, o});
      do apb(0, `REG_STAT, 0); while (rd[`STAT_BUSY] !== 1'b0);
   endtask : run
   task automatic rdt(input logic [31:0] e);
      run(OP_DATA, 0);
      apb(0, `REG_RDATA, 0);
      `CHK("read data", e, rd)
   endtask : rdt
   task automatic getf(input logic [7:0] a, input logic [31:0] e);
      apb(1, `REG_FEAT, {24'h0, a});
      run(OP_GETF, 0);
      apb(0, `REG_RDATA, 0);
      `CHK("feature", e, rd)
   endtask : getf
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 4; i++) begin
         apb(1, `REG_FEAT, {24'h0, fa[i]});
         apb(1, `REG_WDATA, wd[i]);
         run(OP_SETF, 0);
         getf(fa[i], ex[i]);
      end
      run(OP_RESET, 0);
      getf(8'h80, 32'h1234_5678);
      apb(1, `REG_ROW0, 32'h0000_0002);
      apb(1, `REG_COL, 32'h0000_0000);
      run(OP_OTP, 0);
      rdt(32'h0504_0302);
      apb(1, `REG_COL, 32'h0000_0010);
      run(OP_RNDOUT, 0);
      rdt(32'h1514_1312);
      apb(1, `REG_ROW0, 32'h0000_000C);
      run(OP_OTP, 0);
      `CHK("page refused", 1'b1, rd[`STAT_ERR])
      apb(1, `REG_STAT, 32'h0000_0002);
      apb(0, `REG_STAT, 0);
      `CHK("error cleared", 1'b0, rd[`STAT_ERR])
      apb(1, `REG_ROW0, 32'h0000_0005);
      apb(1, `REG_ROW1, 32'h0000_0085);
      apb(1, `REG_COL, 32'h0000_0020);
      run(OP_TPREAD, 0);
      rdt(32'hC3C2_C1C0);
      run(OP_RESEL, 1);
      rdt(32'hD3D2_D1D0);
      apb(1, `REG_COL, 32'h0000_0024);
      run(OP_RNDOUT, 1);
      rdt(32'hD7D6_D5D4);
      apb(1, `REG_CTRL, {27'h0, 1'b0, OP_OTP});
      do apb(0, `REG_STAT, 0); while (rd[`STAT_RB] !== 1'b0);
      apb(1, `REG_CTRL, {27'h0, 1'b0, OP_SETF});
      apb(0, `REG_STAT, 0);
      `CHK("busy refused", 1'b1, rd[`STAT_ERR])
      do apb(0, `REG_STAT, 0); while (rd[`STAT_BUSY] !== 1'b0);
      apb(1, `REG_STAT, 32'h0000_0002);
      apb(1, `REG_ROW1, 32'h0000_0105);
      run(OP_TPREAD, 0);
      `CHK("pair refused", 1'b1, rd[`STAT_ERR])
      run(OP_STATUS, 0);
      `CHK("status byte", 8'h60, rd[15:8])
      apb(0, 12'h020, 0);
      `CHK("unmapped", 1'b1, se)
      presetn <= 0;
      @(posedge pclk);
      `CHK("reset pins", 5'b11100, {ce_n, we_n, read_strobe_n, io_oe, pready})
      presetn <= 1;
      apb(0, `REG_STAT, 0);
      `CHK("reset status", 3'b100, rd[2:0])
      final_report();
   end
endmodule : nand_host_ctl_test

// ===== nand_host_pkg.sv
// nand_host_pkg.sv: types shared by the nand host controller
// assumes nothing beyond the constants header
package nand_host_pkg;

   // ==========================================================
   // orders that software writes into the control register
   typedef enum logic [3:0] {
      OP_NONE   = 4'b0000,
      OP_OTP    = 4'b0001,
      OP_GETF   = 4'b0010,
      OP_SETF   = 4'b0011,
      OP_TPREAD = 4'b0100,
      OP_RESEL  = 4'b0101,
      OP_RNDOUT = 4'b0110,
      OP_STATUS = 4'b0111,
      OP_RESET  = 4'b1000,
      OP_DATA   = 4'b1001
   } order_t;

   // kind of one bus cycle in a sequence
   typedef enum logic [2:0] {
      K_CMD  = 3'b000,
      K_ADR  = 3'b001,
      K_DIN  = 3'b010,
      K_DOUT = 3'b011,
      K_WAIT = 3'b100,
      K_END  = 3'b101
   } kind_t;

   // sequencer phases
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_LOW   = 3'b010,
      S_HIGH  = 3'b011,
      S_WB    = 3'b100,
      S_RB    = 3'b101
   } phase_t;

   typedef struct packed {
      kind_t       kind;
      logic [7:0]  data;
   } slot_t;

   // whole state of the controller
   typedef struct packed {
      phase_t      phase;
      order_t      order;
      logic [3:0]  slot;
      logic [4:0]  cnt;
      logic [15:0] col;
      logic [23:0] row0;
      logic [23:0] row1;
      logic [7:0]  feat;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [7:0]  status;
      logic        plane;
      logic        err;
      logic        ce_n;
      logic        cle;
      logic        ale;
      logic        we_n;
      logic        read_strobe_n;
      logic [7:0]  io_out;
      logic        io_oe;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } ctl_state_t;

endpackage : nand_host_pkg

// ===== nand_host_sync.sv
// nand_host_sync.sv: two-flop synchroniser for pin inputs
// assumes the input is asynchronous to pclk
`timescale 1ns/1ns
module nand_host_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;   // first stage, read only by second

   // two stages, constant reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta     <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule : nand_host_sync
